// ---- inc/laser_range_merge_spi_map.svh ----
// register map, field positions, reset values and range figures of the laser range/merge block
`ifndef LASER_RANGE_MERGE_SPI_MAP_SVH
`define LASER_RANGE_MERGE_SPI_MAP_SVH
// -----------------------------------------------
// register offsets
// -----------------------------------------------
`define REG_STATUS 6'h01
`define REG_CH1_LIMIT 6'h11
`define REG_CH2_LIMIT 6'h16
`define REG_MERGE_CTRL 6'h1b
`define REG_RANGE 6'h1e
`define ADDR_LAST 6'h3f
// -----------------------------------------------
// field positions and reset values
// -----------------------------------------------
`define STAT_RAIL1_BIT 3
`define STAT_RAIL2_BIT 7
`define MERGE_BIT 6
`define RANGE_CH1_LSB 0
`define RANGE_CH2_LSB 4
`define LIMIT_RESET 8'hff
`define RANGE_RESET 2'h0
`define MERGE_RESET 1'b0
`define FLAG_RESET 1'b1
// -----------------------------------------------
// opcodes in bits 7:6 of the address byte
// -----------------------------------------------
`define OP_READ 2'h2
`define OP_WRITE 2'h1
// -----------------------------------------------
// single-channel range full scale, in 0.1 mA
// -----------------------------------------------
`define RNG_FULL 14'h1d4c
`define RNG_MID 14'h03e8
`define RNG_LOW 14'h00fa
`define RNG_MIN 14'h005a
`define RNG_S_FULL 14'h0384
`define RNG_S_MID 14'h0078
`define RNG_S_LOW 14'h001e
`define RNG_S_MIN 14'h000b
`endif

// ---- inc/laser_range_merge_spi_pkg.sv ----
// types shared by the laser range/merge register block
package laser_range_merge_spi_pkg;
	// configuration written over the serial port
	typedef struct packed {
		logic merge;
		logic [7:0] ch1_overcurrent_limit;
		logic [7:0] ch2_overcurrent_limit;
		logic [1:0] ch1_range_sel;
		logic [1:0] ch2_range_sel;
	} cfg_t;
	// sticky supply flags
	typedef struct packed {
		logic rail2_mismatch_flag;
		logic rail1_powerdown_flag;
	} status_t;
endpackage : laser_range_merge_spi_pkg

// ---- hw/laser_range_merge_spi_regs.sv ----
// serial slave, configuration registers and supply supervision of the laser range/merge block
`timescale 1ns/10ps
`include "laser_range_merge_spi_map.svh"
module laser_range_merge_spi_regs (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic spi_sclk_i,
	input wire logic chip_select_addr1_pin_n_i,
	input wire logic serial_in_addr0_pin_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	input wire logic interface_select_pin_i,
	input wire logic laser_supply_one_pd_i,
	input wire logic laser_supply_two_pd_i,
	input wire logic supply_mismatch_i,
	input wire logic range_scale_bit_i,
	input wire logic ch2_range_scale_bit_i,
	input wire logic ch1_current_ctrl_sel_i,
	input wire logic ch2_current_ctrl_sel_i,
	output logic merge_o,
	output logic ch2_loop_enable_o,
	output logic ch1_laser_enable_o,
	output logic ch2_laser_enable_o,
	output logic [7:0] ch1_overcurrent_limit_o,
	output logic [7:0] ch2_overcurrent_limit_o,
	output logic ch1_ocp_active_o,
	output logic ch2_ocp_active_o,
	output logic [13:0] eff_range_o
);

	// -----------------------------------------------
	// helpers
	// -----------------------------------------------
	// full scale of one channel for a range code and scale bit
	function automatic logic [13:0] range_of(input logic [1:0] code, input logic scale);
		logic [13:0] r;
		r = 14'h0000;
		unique case ({scale, code})
			3'h0: r = `RNG_FULL;
			3'h1: r = `RNG_MID;
			3'h2: r = `RNG_LOW;
			3'h3: r = `RNG_MIN;
			3'h4: r = `RNG_S_FULL;
			3'h5: r = `RNG_S_MID;
			3'h6: r = `RNG_S_LOW;
			3'h7: r = `RNG_S_MIN;
		endcase
		return r;
	endfunction : range_of

	// register read view, unused bits read zero
	function automatic logic [7:0] read_reg(input logic [5:0] a,
			input laser_range_merge_spi_pkg::cfg_t c,
			input laser_range_merge_spi_pkg::status_t s);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			`REG_STATUS: begin
				d[`STAT_RAIL1_BIT] = s.rail1_powerdown_flag;
				d[`STAT_RAIL2_BIT] = s.rail2_mismatch_flag;
			end
			`REG_CH1_LIMIT: d = c.ch1_overcurrent_limit;
			`REG_CH2_LIMIT: d = c.ch2_overcurrent_limit;
			`REG_MERGE_CTRL: d[`MERGE_BIT] = c.merge;
			`REG_RANGE: begin
				d[`RANGE_CH1_LSB +: 2] = c.ch1_range_sel;
				d[`RANGE_CH2_LSB +: 2] = c.ch2_range_sel;
			end
			default: d = 8'h00;
		endcase
		return d;
	endfunction : read_reg

	// -----------------------------------------------
	// link side, serial clock domain
	// -----------------------------------------------
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [6:0] shift_in, next_shift_in;
	logic [5:0] addr, next_addr;
	logic [1:0] op, next_op;
	logic addr_ok, next_addr_ok;
	logic wr_tgl, next_wr_tgl;
	logic [5:0] wr_addr, next_wr_addr;
	logic [7:0] wr_data, next_wr_data;
	logic clr_tgl, next_clr_tgl;
	logic [7:0] clr_mask, next_clr_mask;
	logic [7:0] tx, next_tx;
	logic [7:0] tx_hold, next_tx_hold;
	logic [1:0] sel_s;
	laser_range_merge_spi_pkg::cfg_t cfg_s1, cfg_s2;
	laser_range_merge_spi_pkg::status_t stat_s1, stat_s2;
	logic [7:0] rx_byte;
	logic spi_on;

	// clock-domain side state, declared here for the synchronisers
	laser_range_merge_spi_pkg::cfg_t cfg, next_cfg;
	laser_range_merge_spi_pkg::status_t flags, next_flags;

	assign rx_byte = {shift_in, serial_in_addr0_pin_i};
	assign spi_on = ~sel_s[1];

	// byte assembly, opcode decode, burst addressing
	always_comb begin
		next_bit_cnt = bit_cnt + 3'h1;
		next_shift_in = rx_byte[6:0];
		next_addr = addr;
		next_op = op;
		next_addr_ok = addr_ok;
		next_wr_tgl = wr_tgl;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_clr_tgl = clr_tgl;
		next_clr_mask = clr_mask;
		if (bit_cnt == 3'h7 && spi_on) begin
			if (!addr_ok) begin
				next_op = rx_byte[7:6];
				next_addr = rx_byte[5:0];
				next_addr_ok = 1'b1;
			end else begin
				if (op == `OP_WRITE) begin
					next_wr_addr = addr;
					next_wr_data = rx_byte;
					next_wr_tgl = ~wr_tgl;
				end
				// only the bits actually shipped are acknowledged
				if (op == `OP_READ && addr == `REG_STATUS) begin
					next_clr_mask = tx_hold;
					next_clr_tgl = ~clr_tgl;
				end
				if (addr == `ADDR_LAST) begin
					next_addr = 6'h00;
				end else begin
					next_addr = addr + 6'h01;
				end
			end
		end
	end

	// frame state, cleared whenever chip select is released
	always_ff @(posedge spi_sclk_i or posedge chip_select_addr1_pin_n_i) begin
		if (chip_select_addr1_pin_n_i) begin
			bit_cnt <= 3'h0;
			shift_in <= 7'h00;
			addr <= 6'h00;
			op <= 2'h0;
			addr_ok <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			shift_in <= next_shift_in;
			addr <= next_addr;
			op <= next_op;
			addr_ok <= next_addr_ok;
		end
	end

	// toggles must survive across frames, so only system reset clears them
	always_ff @(posedge spi_sclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_tgl <= 1'b0;
			wr_addr <= 6'h00;
			wr_data <= 8'h00;
			clr_tgl <= 1'b0;
			clr_mask <= 8'h00;
			sel_s <= 2'h3;
			cfg_s1 <= '0;
			cfg_s2 <= '0;
			stat_s1 <= '0;
			stat_s2 <= '0;
		end else begin
			wr_tgl <= next_wr_tgl;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			clr_tgl <= next_clr_tgl;
			clr_mask <= next_clr_mask;
			sel_s <= {sel_s[0], interface_select_pin_i};
			cfg_s1 <= cfg; // quasi-static, settles long before a read
			cfg_s2 <= cfg_s1;
			stat_s1 <= flags;
			stat_s2 <= stat_s1;
		end
	end

	// transmit shifter, loaded when a new byte starts
	always_comb begin
		next_tx = {tx[6:0], 1'b0};
		next_tx_hold = tx_hold;
		if (bit_cnt == 3'h0) begin
			next_tx = read_reg(addr, cfg_s2, stat_s2);
			next_tx_hold = next_tx;
		end
	end

	// data out changes on the falling edge
	always_ff @(negedge spi_sclk_i or posedge chip_select_addr1_pin_n_i) begin
		if (chip_select_addr1_pin_n_i) begin
			tx <= 8'h00;
			tx_hold <= 8'h00;
		end else begin
			tx <= next_tx;
			tx_hold <= next_tx_hold;
		end
	end

	assign serial_out_o = tx[7];
	// driven only in the data phase of a read frame
	assign serial_out_oe_o = addr_ok & (op == `OP_READ) & spi_on
		& ~chip_select_addr1_pin_n_i;

	// -----------------------------------------------
	// system clock domain
	// -----------------------------------------------
	logic [2:0] wr_s, clr_s;
	logic [1:0] pd1_s, pd2_s, mis_s;
	logic wr_pulse, clr_pulse;
	logic ev_rail1, ev_rail2;
	logic [1:0] clr_bits;
	logic next_ch1_en, next_ch2_en, next_ocp1, next_ocp2;
	logic [13:0] next_range;
	logic scale2;

	// toggle and pin synchronisers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_s <= 3'h0;
			clr_s <= 3'h0;
			pd1_s <= 2'h0;
			pd2_s <= 2'h0;
			mis_s <= 2'h0;
		end else begin
			wr_s <= {wr_s[1:0], wr_tgl};
			clr_s <= {clr_s[1:0], clr_tgl};
			pd1_s <= {pd1_s[0], laser_supply_one_pd_i};
			pd2_s <= {pd2_s[0], laser_supply_two_pd_i};
			mis_s <= {mis_s[0], supply_mismatch_i};
		end
	end

	assign wr_pulse = wr_s[2] ^ wr_s[1];
	assign clr_pulse = clr_s[2] ^ clr_s[1];

	// register writes; address and data held stable across the toggle
	always_comb begin
		next_cfg = cfg;
		if (wr_pulse) begin
			unique case (wr_addr)
				`REG_CH1_LIMIT: next_cfg.ch1_overcurrent_limit = wr_data;
				`REG_CH2_LIMIT: next_cfg.ch2_overcurrent_limit = wr_data;
				`REG_MERGE_CTRL: next_cfg.merge = wr_data[`MERGE_BIT];
				`REG_RANGE: begin
					next_cfg.ch1_range_sel = wr_data[`RANGE_CH1_LSB +: 2];
					next_cfg.ch2_range_sel = wr_data[`RANGE_CH2_LSB +: 2];
				end
				default: next_cfg = cfg;
			endcase
		end
	end

	// supply events and sticky flags; a new event beats the clear
	assign ev_rail1 = pd1_s[1] | (cfg.merge & pd2_s[1]);
	assign ev_rail2 = cfg.merge ? mis_s[1] : pd2_s[1];
	assign clr_bits = clr_pulse ? {clr_mask[`STAT_RAIL2_BIT], clr_mask[`STAT_RAIL1_BIT]} : 2'h0;

	always_comb begin
		next_flags.rail1_powerdown_flag = (flags.rail1_powerdown_flag & ~clr_bits[0])
			| ev_rail1;
		next_flags.rail2_mismatch_flag = (flags.rail2_mismatch_flag & ~clr_bits[1])
			| ev_rail2;
	end

	// channel control outputs, registered
	assign scale2 = ch1_current_ctrl_sel_i ? range_scale_bit_i : ch2_range_scale_bit_i;
	always_comb begin
		// pending flags keep both channels off until acknowledged
		next_ch1_en = ~(flags.rail1_powerdown_flag | flags.rail2_mismatch_flag);
		next_ch2_en = next_ch1_en;
		// zero disables protection only in current control
		next_ocp1 = ~(ch1_current_ctrl_sel_i & (cfg.ch1_overcurrent_limit == 8'h00));
		next_ocp2 = ~(ch2_current_ctrl_sel_i & (cfg.ch2_overcurrent_limit == 8'h00));
		if (cfg.merge) begin
			next_range = range_of(cfg.ch1_range_sel, range_scale_bit_i)
				+ range_of(cfg.ch2_range_sel, scale2);
		end else begin
			next_range = range_of(cfg.ch1_range_sel, range_scale_bit_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg.merge <= `MERGE_RESET;
			cfg.ch1_overcurrent_limit <= `LIMIT_RESET;
			cfg.ch2_overcurrent_limit <= `LIMIT_RESET;
			cfg.ch1_range_sel <= `RANGE_RESET;
			cfg.ch2_range_sel <= `RANGE_RESET;
			flags.rail1_powerdown_flag <= `FLAG_RESET;
			flags.rail2_mismatch_flag <= `FLAG_RESET;
			ch1_laser_enable_o <= 1'b0;
			ch2_laser_enable_o <= 1'b0;
			ch1_ocp_active_o <= 1'b1;
			ch2_ocp_active_o <= 1'b1;
			eff_range_o <= 14'h0000;
		end else begin
			cfg <= next_cfg;
			flags <= next_flags;
			ch1_laser_enable_o <= next_ch1_en;
			ch2_laser_enable_o <= next_ch2_en;
			ch1_ocp_active_o <= next_ocp1;
			ch2_ocp_active_o <= next_ocp2;
			eff_range_o <= next_range;
		end
	end

	// channel two follows channel one's regulation when combined
	assign merge_o = cfg.merge;
	assign ch2_loop_enable_o = ~cfg.merge;
	assign ch1_overcurrent_limit_o = cfg.ch1_overcurrent_limit;
	assign ch2_overcurrent_limit_o = cfg.ch2_overcurrent_limit;

endmodule : laser_range_merge_spi_regs

// ---- dv/spi_host_model.sv ----
// serial master model that drives the laser block's slave port
`timescale 1ns/10ps
module spi_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	// clock rests low outside frames
	// chip select rises by non-blocking assignment so the slave's frame reset sees it
	initial begin
		sclk_o = 1'b0;
		cs_n_o <= 1'b1;
		mosi_o = 1'b0;
	end
	// -------------------------------------------
	// one header byte, then three data bytes
	// -------------------------------------------
	// the odd start delay keeps the serial clock out of phase with the system clock
	task automatic xfer(input logic [31:0] tx, output logic [23:0] rx);
		cs_n_o = 1'b0;
		#19;
		for (int i = 31; i >= 0; i--) begin
			mosi_o = tx[i];
			#16 sclk_o = 1'b1;
			if (i < 24) rx[i] = miso_i;
			#16 sclk_o = 1'b0;
		end
		#16 cs_n_o = 1'b1;
		mosi_o = ~mosi_o; // released line must not look like held data
		#32;
	endtask : xfer
endmodule : spi_host_model

// ---- dv/laser_range_merge_spi_asserts.sv ----
// port assertions for the laser range/merge register block
`timescale 1ns/10ps
module laser_range_merge_spi_asserts (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic chip_select_addr1_pin_n_i,
	input wire logic serial_out_oe_o,
	input wire logic laser_supply_one_pd_i,
	input wire logic supply_mismatch_i,
	input wire logic range_scale_bit_i,
	input wire logic ch1_current_ctrl_sel_i,
	input wire logic merge_o,
	input wire logic ch2_loop_enable_o,
	input wire logic ch1_laser_enable_o,
	input wire logic ch2_laser_enable_o,
	input wire logic [7:0] ch1_overcurrent_limit_o,
	input wire logic ch1_ocp_active_o,
	input wire logic [13:0] eff_range_o
);
	// -------------------------------------------
	// all checks run in the system clock domain
	// -------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	ena_pair_a: assert property (ch1_laser_enable_o == ch2_laser_enable_o)
		else $error("channel enables disagree");
	loop_merge_a: assert property (ch2_loop_enable_o != merge_o)
		else $error("channel two loop not inverse of merge");
	// a zero limit only switches protection off under current control
	ocp_zero_a: assert property (ch1_ocp_active_o !=
		($past(ch1_current_ctrl_sel_i) && $past(ch1_overcurrent_limit_o) == 8'h00))
		else $error("overcurrent enable wrong");
	rst_vals_a: assert property ($fell(sys_rst_i) |->
		ch1_overcurrent_limit_o == 8'hff && !merge_o)
		else $error("reset values wrong");
	rng_rst_a: assert property ($fell(sys_rst_i) && !range_scale_bit_i |=>
		eff_range_o == 14'h1d4c)
		else $error("reset range not full scale");
	ena_rst_a: assert property ($fell(sys_rst_i) |-> !ch1_laser_enable_o [*8])
		else $error("enabled before status read");
	pd_ena_a: assert property (laser_supply_one_pd_i [*6] |-> !ch1_laser_enable_o)
		else $error("enabled during supply power down");
	mism_ena_a: assert property ((merge_o && supply_mismatch_i) [*6] |->
		!ch2_laser_enable_o)
		else $error("enabled with supply mismatch");
	oe_idle_a: assert property (chip_select_addr1_pin_n_i |-> !serial_out_oe_o)
		else $error("data out driven while deselected");
endmodule : laser_range_merge_spi_asserts
bind laser_range_merge_spi_regs laser_range_merge_spi_asserts chk_u (.clk_i, .sys_rst_i,
	.chip_select_addr1_pin_n_i, .serial_out_oe_o, .laser_supply_one_pd_i, .supply_mismatch_i,
	.range_scale_bit_i, .ch1_current_ctrl_sel_i, .merge_o, .ch2_loop_enable_o,
	.ch1_laser_enable_o, .ch2_laser_enable_o, .ch1_overcurrent_limit_o, .ch1_ocp_active_o,
	.eff_range_o);

// ---- dv/tb.sv ----
// self-checking bench of the laser range/merge register block
`timescale 1ns/10ps
`include "laser_range_merge_spi_map.svh"
module tb;
	logic clk_i, sys_rst_i, interface_select_pin_i, supply_mismatch_i;
	logic laser_supply_one_pd_i, laser_supply_two_pd_i, range_scale_bit_i, ch2_range_scale_bit_i;
	logic ch1_current_ctrl_sel_i, ch2_current_ctrl_sel_i, merge_o, ch2_loop_enable_o;
	logic spi_sclk_i, chip_select_addr1_pin_n_i, serial_in_addr0_pin_i;
	logic serial_out_o, serial_out_oe_o, ch1_laser_enable_o, ch2_laser_enable_o;
	logic ch1_ocp_active_o, ch2_ocp_active_o;
	logic [7:0] ch1_overcurrent_limit_o, ch2_overcurrent_limit_o;
	logic [13:0] eff_range_o;
	logic [23:0] rx;
	int err_total = 0;
	int checks_done = 0;
	logic [5:0] ra [4] = '{6'h11, 6'h16, 6'h1b, 6'h1e};
	logic [7:0] rv [4] = '{8'hff, 8'hff, 8'h00, 8'h00};
	logic [13:0] rng [4] = '{`RNG_FULL, `RNG_MID, `RNG_LOW, `RNG_MIN};
	logic [3:0] evc [5] = '{4'h8, 4'ha, 4'h2, 4'h0, 4'h1};
	logic [7:0] evx [5] = '{8'h80, 8'h08, 8'h80, 8'h00, 8'h08};
	// a released data line shows the inverse, so stale bits cannot pass
	wire logic miso = serial_out_oe_o ? serial_out_o : ~serial_out_o;
	laser_range_merge_spi_regs dut (.clk_i, .sys_rst_i, .spi_sclk_i, .chip_select_addr1_pin_n_i,
		.serial_in_addr0_pin_i, .serial_out_o, .serial_out_oe_o, .interface_select_pin_i,
		.laser_supply_one_pd_i, .laser_supply_two_pd_i, .supply_mismatch_i, .range_scale_bit_i,
		.ch2_range_scale_bit_i, .ch1_current_ctrl_sel_i, .ch2_current_ctrl_sel_i, .merge_o,
		.ch2_loop_enable_o, .ch1_laser_enable_o, .ch2_laser_enable_o, .ch1_overcurrent_limit_o,
		.ch2_overcurrent_limit_o, .ch1_ocp_active_o, .ch2_ocp_active_o, .eff_range_o);
	spi_host_model host (.sclk_o(spi_sclk_i), .cs_n_o(chip_select_addr1_pin_n_i),
		.mosi_o(serial_in_addr0_pin_i), .miso_i(miso));
	// -------------------------------------------
	// helpers
	// -------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// writes land a few system clocks after the byte, so settle before looking
	task automatic fr(input logic [31:0] tx);
		host.xfer(tx, rx);
		repeat (8) @(negedge clk_i);
	endtask : fr
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// a hang is cut short well after the sequence should have ended
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end
	// -------------------------------------------
	// test sequence
	// -------------------------------------------
	initial begin
		// non-blocking, so the slave's asynchronous resets are armed when the edge comes
		{sys_rst_i, interface_select_pin_i, supply_mismatch_i, laser_supply_one_pd_i} <= 4'h8;
		{laser_supply_two_pd_i, range_scale_bit_i, ch2_range_scale_bit_i} = 3'h0;
		{ch1_current_ctrl_sel_i, ch2_current_ctrl_sel_i} = 2'h0;
		repeat (10) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk({merge_o, ch1_laser_enable_o, ch1_ocp_active_o}, 3'b001);
		chk({ch1_overcurrent_limit_o, ch2_overcurrent_limit_o}, 16'hffff);
		chk(eff_range_o, `RNG_FULL);
		for (int i = 0; i < 4; i++) begin
			fr({2'h2, ra[i], 24'h0});
			chk(rx, {rv[i], 16'h0});
		end
		$display("reset values done");
		// status sits two places past the top address
		fr({2'h2, 6'h3f, 24'h0});
		chk(rx, 24'h000088);
		chk(ch1_laser_enable_o & ch2_laser_enable_o, 1'b1);
		fr({2'h2, 6'h01, 24'h0});
		chk(rx, 24'h0);
		$display("status clear done");
		fr({2'h1, 6'h11, 24'h00a5c3});
		fr({2'h1, 6'h16, 24'h0});
		for (int m = 0; m < 2; m++) begin
			{ch1_current_ctrl_sel_i, ch2_current_ctrl_sel_i} = {2{m[0]}};
			repeat (2) @(negedge clk_i);
			chk({ch1_ocp_active_o, ch2_ocp_active_o}, {2{~m[0]}});
		end
		fr({2'h1, 6'h11, 24'h7e0000});
		fr({2'h2, 6'h11, 24'h0});
		chk({rx, ch1_overcurrent_limit_o}, 32'h7e00007e);
		$display("limits done");
		// unknown opcodes and a deselected port must leave the limit alone
		fr({2'h0, 6'h11, 24'h110000});
		fr({2'h3, 6'h11, 24'h220000});
		interface_select_pin_i = 1'b1;
		fr({2'h1, 6'h11, 24'h330000});
		interface_select_pin_i = 1'b0;
		fr({2'h0, 6'h3f, 24'h0});
		chk(ch1_overcurrent_limit_o, 8'h7e);
		$display("refusals done");
		fr({2'h1, 6'h1e, 24'h210000});
		chk(eff_range_o, `RNG_MID);
		// reference and capacitor enable stay untouched, they live outside this block
		fr({2'h1, 6'h1b, 24'h400000}); // limits 0x7e and 0x00 in current control
		chk({merge_o, ch2_loop_enable_o, eff_range_o}, {2'b10, `RNG_MID + `RNG_LOW});
		range_scale_bit_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk(eff_range_o, `RNG_S_MID + `RNG_S_LOW);
		range_scale_bit_i = 1'b0;
		for (int c = 0; c < 4; c++) begin
			fr({2'h1, 6'h1e, 2'h0, c[1:0], 2'h0, c[1:0], 16'h0});
			chk(eff_range_o, rng[c] + rng[c]);
		end
		// power control takes channel two's own scale bit; its limit must sit at the top
		fr({2'h1, 6'h16, 24'hff0000});
		{ch1_current_ctrl_sel_i, ch2_current_ctrl_sel_i, ch2_range_scale_bit_i} = 3'h1;
		repeat (2) @(negedge clk_i);
		chk(eff_range_o, `RNG_MIN + `RNG_S_MIN);
		chk({ch2_overcurrent_limit_o, ch2_ocp_active_o}, 9'h1ff);
		{ch1_current_ctrl_sel_i, ch2_current_ctrl_sel_i, ch2_range_scale_bit_i} = 3'h6;
		$display("ranges done");
		// each supply event separate, mismatch and supply two power down merged, then acknowledged by a read
		for (int e = 0; e < 5; e++) begin
			fr({2'h1, 6'h1b, 1'b0, evc[e][3], 22'h0});
			{laser_supply_two_pd_i, laser_supply_one_pd_i, supply_mismatch_i} = 3'b001 << evc[e][1:0];
			repeat (10) @(negedge clk_i);
			chk(ch1_laser_enable_o, evx[e] == 8'h00);
			{laser_supply_two_pd_i, laser_supply_one_pd_i, supply_mismatch_i} = 3'h0;
			fr({2'h2, 6'h01, 24'h0});
			chk(rx[23:16], evx[e]);
		end
		$display("supply events done");
		give_verdict();
	end
endmodule : tb
